// ---- rtl/pressure_readout_pkg.sv ----
// Constants shared by the pressure sensor command and readout logic
package pressure_readout_pkg;
   // Bus address and command bytes
   localparam logic [6:0] DEV_ADDR        = 7'h78;
   localparam logic [7:0] CMD_MEAS_STORED = 8'hAC;
   localparam logic [3:0] CMD_MEAS_OSR_HI = 4'hB;
   // Status byte field positions
   localparam int         STAT_POWER_BIT  = 6;
   localparam int         STAT_BUSY_BIT   = 5;
   localparam int         STAT_MODE_BIT   = 3;
   localparam int         STAT_CRC_BIT    = 2;
   localparam logic [7:0] STAT_RESET      = 8'h00;
   // Command low nibble layout
   localparam int         TEMPERATURE_OVERSAMPLING_SELECT_BIT       = 3;
   localparam int         PRESSURE_OVERSAMPLING_SELECT_W         = 3;
   // Result widths and code ranges
   localparam int         PRESS_W         = 24;
   localparam int         TEMP_W          = 16;
   localparam int         RESULT_BYTES    = 6;
   localparam logic [23:0] PRESS_CODE_LO  = 24'd1677722;
   localparam logic [23:0] PRESS_CODE_HI  = 24'd15099494;
   localparam logic [15:0] TEMP_CODE_HI   = 16'hFFFF;
   localparam logic [7:0] TX_IDLE_BYTE    = 8'h00;
endpackage : pressure_readout_pkg

// ---- rtl/pressure_readout_if.sv ----
// Interfaces between the line sampler, the command logic and the sequencer
`timescale 1ns/1ps
`default_nettype none
interface line_event_if;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic sda;
   modport drv (output scl_rise, scl_fall, start_det, stop_det, sda);
   modport usr (input  scl_rise, scl_fall, start_det, stop_det, sda);
endinterface : line_event_if

interface meas_ctl_if;
   logic       start;
   logic       temp_osr;
   logic [2:0] press_osr;
   logic       busy;
   logic       done;
   modport ctl (output start, temp_osr, press_osr, input busy, done);
   modport seq (input start, temp_osr, press_osr, output busy, done);
endinterface : meas_ctl_if
`default_nettype wire

// ---- rtl/line_sampler.sv ----
// Two-stage synchroniser and start, stop and edge detection for the bus lines
`timescale 1ns/1ps
`default_nettype none
module line_sampler (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   // Bus pins
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   // Events
   line_event_if.drv       ev
);
   typedef struct packed {
      logic scl_m;
      logic sda_m;
      logic scl_s;
      logic sda_s;
      logic scl_p;
      logic sda_p;
   } smp_t;

   smp_t s_q, s_d;

   always_comb begin
      s_d       = s_q;
      s_d.scl_m = scl_i;
      s_d.sda_m = sda_i;
      s_d.scl_s = s_q.scl_m;
      s_d.sda_s = s_q.sda_m;
      s_d.scl_p = s_q.scl_s;
      s_d.sda_p = s_q.sda_s;
   end

   // Idle bus is high, so reset to high to avoid a false edge
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_q <= '1;
      end else begin
         s_q <= s_d;
      end
   end

   assign ev.scl_rise  = s_q.scl_s & ~s_q.scl_p;
   assign ev.scl_fall  = ~s_q.scl_s & s_q.scl_p;
   assign ev.start_det = s_q.scl_s & s_q.scl_p & ~s_q.sda_s & s_q.sda_p;
   assign ev.stop_det  = s_q.scl_s & s_q.scl_p & s_q.sda_s & ~s_q.sda_p;
   assign ev.sda       = s_q.sda_s;
endmodule : line_sampler
`default_nettype wire

// ---- rtl/measurement_sequencer.sv ----
// One-shot measurement sequencer with deep sleep after each conversion outside test mode
`timescale 1ns/1ps
`default_nettype none
module measurement_sequencer (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   // Command side
   meas_ctl_if.seq         m,
   input  wire logic       test_mode_i,
   // Front end
   input  wire logic       fe_done_i,
   output logic            fe_start_o,
   output logic            temperature_oversampling_select_o,
   output logic [2:0]      pressure_oversampling_select_o,
   output logic            deep_sleep_o
);
   typedef enum logic [1:0] {
      SLEEP = 2'b01,
      RUN   = 2'b10
   } seq_st_t;

   typedef struct packed {
      seq_st_t    st;
      logic       fe_start;
      logic       done;
      logic       sleep;
      logic       temperature_oversampling_select;
      logic [2:0] pressure_oversampling_select;
   } seq_t;

   seq_t s_q, s_d;

   always_comb begin
      s_d          = s_q;
      s_d.fe_start = 1'b0;
      s_d.done     = 1'b0;
      unique case (s_q.st)
         SLEEP: begin
            if (m.start) begin
               s_d.st       = RUN;                    // [R14]
               s_d.fe_start = 1'b1;
               s_d.temperature_oversampling_select    = m.temp_osr;             // [R13]
               s_d.pressure_oversampling_select    = m.press_osr;            // [R13]
            end
         end
         RUN: begin
            if (fe_done_i) begin
               s_d.st   = SLEEP;                      // [R14]
               s_d.done = 1'b1;
            end
         end
      endcase
      // Test mode keeps the front end powered between conversions
      s_d.sleep = (s_d.st == SLEEP) & ~test_mode_i;   // [R14] [R8]
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_q <= '{st: SLEEP, sleep: 1'b1, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign m.busy                            = (s_q.st == RUN);
   assign m.done                            = s_q.done;
   assign fe_start_o                        = s_q.fe_start;
   assign temperature_oversampling_select_o = s_q.temperature_oversampling_select;
   assign pressure_oversampling_select_o    = s_q.pressure_oversampling_select;
   assign deep_sleep_o                      = s_q.sleep;
endmodule : measurement_sequencer
`default_nettype wire

// ---- rtl/pressure_readout.sv ----
// Bus command decoder, status byte and result readout of the pressure sensor
`timescale 1ns/1ps
`default_nettype none
// Operation
// (R1) Answer bus address 0x78, bytes F0/F1
// (R2) Every read starts with the status byte
// (R3) Repeated reads return identical data
// (R4) Non-read command invalidates held results
// (R5) Bit6 power on; bits 7,4,1,0 zero
// (R6) Bit5 busy until requested result valid
// (R7) Commands ignored while busy
// (R8) Bit3 shows single-shot or test mode
// (R9) Bit2 set when calibration CRC failed
// (R10) CRC evaluated once, at reset only
// (R11) 0xAC measures with stored oversampling
// (R12) 0xB0-0xBF measure with nibble oversampling
// (R13) Nibble bit3 temperature, bits2:0 pressure oversampling
// (R14) One measurement per command, then sleep; code stays out of deep sleep in test mode
// (R15) Host writes address then command
// (R16) Host waits for measurement before reading
// (R17) Read order: status, three pressure, two temperature
// (R18) Pressure is unsigned 24-bit code
// (R19) Temperature is unsigned 16-bit code
// (R20) All bytes travel MSB first
// (R21) Host acks result bytes except last
// (R22) Host rereads until busy clears
module pressure_readout
   import pressure_readout_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = pressure_readout_pkg::DEV_ADDR
) (
   // Clock and reset
   input  wire logic                                  clk_i,
   input  wire logic                                  sys_rst_i,
   // Bus pins, open drain data
   input  wire logic                                  scl_i,
   input  wire logic                                  sda_i,
   output logic                                       sda_o,
   output logic                                       sda_oe_n_o,
   // Calibration memory
   input  wire logic                                  cal_crc_fail_i,
   input  wire logic                                  cal_temp_osr_i,
   input  wire logic [pressure_readout_pkg::PRESSURE_OVERSAMPLING_SELECT_W-1:0] cal_press_osr_i,
   input  wire logic                                  test_mode_i,
   // Measurement front end
   input  wire logic                                  fe_done_i,
   input  wire logic [pressure_readout_pkg::PRESS_W-1:0] fe_press_i,
   input  wire logic [pressure_readout_pkg::TEMP_W-1:0]  fe_temp_i,
   output logic                                       fe_start_o,
   output logic                                       temperature_oversampling_select_o,
   output logic [pressure_readout_pkg::PRESSURE_OVERSAMPLING_SELECT_W-1:0]   pressure_oversampling_select_o,
   output logic                                       deep_sleep_o
);
   import pressure_readout_pkg::*;

   // Reserved address groups would collide with bus-wide codes
   if (SLAVE_ADDR[6:3] == 4'h0 || SLAVE_ADDR[6:3] == 4'hF) begin : g_addr_chk
      $error("Slave address falls in a reserved group");
   end

   // The read stream carries three pressure and two temperature bytes
   if (PRESS_W != 3 * 8 || TEMP_W != 2 * 8) begin : g_width_chk
      $error("Result widths do not fit the read stream layout");
   end

   // Stream length is the status byte plus the result bytes
   if (RESULT_BYTES != 1 + (PRESS_W + TEMP_W) / 8) begin : g_len_chk
      $error("Read stream length does not match the result widths");
   end

   // Temperature select sits just above the pressure field in the nibble
   if (TEMPERATURE_OVERSAMPLING_SELECT_BIT != PRESSURE_OVERSAMPLING_SELECT_W || TEMPERATURE_OVERSAMPLING_SELECT_BIT > 3) begin : g_nibble_chk
      $error("Oversampling fields do not fit the command nibble");
   end

   // All status flags live in the one status byte
   if (STAT_POWER_BIT > 7 || STAT_BUSY_BIT > 7 ||
       STAT_MODE_BIT > 7 || STAT_CRC_BIT > 7) begin : g_stat_chk
      $error("Status flag positions fall outside the status byte");
   end

   typedef enum logic [6:0] {
      IDLE     = 7'b0000001,
      ADDR     = 7'b0000010,
      ADDR_ACK = 7'b0000100,
      WR_BYTE  = 7'b0001000,
      WR_ACK   = 7'b0010000,
      RD_BYTE  = 7'b0100000,
      RD_ACK   = 7'b1000000
   } bus_st_t;

   typedef struct packed {
      bus_st_t            st;
      logic [3:0]         cnt;
      logic [7:0]         sh;
      logic               rd;
      logic               cmd_seen;
      logic [2:0]         idx;
      logic               oe_n;
      logic               valid;
      logic               crc_err;
      logic               crc_taken;
      logic               start;
      logic               temperature_oversampling_select;
      logic [PRESSURE_OVERSAMPLING_SELECT_W-1:0] pressure_oversampling_select;
      logic [PRESS_W-1:0] press;
      logic [TEMP_W-1:0]  temp;
   } ctl_t;

   ctl_t s_q, s_d;

   line_event_if ev ();
   meas_ctl_if   m ();

   line_sampler u_line_sampler (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .scl_i     (scl_i),
      .sda_i     (sda_i),
      .ev        (ev.drv)
   );

   measurement_sequencer u_measurement_sequencer (
      .clk_i                             (clk_i),
      .sys_rst_i                         (sys_rst_i),
      .m                                 (m.seq),
      .test_mode_i                       (test_mode_i),
      .fe_done_i                         (fe_done_i),
      .fe_start_o                        (fe_start_o),
      .temperature_oversampling_select_o (temperature_oversampling_select_o),
      .pressure_oversampling_select_o    (pressure_oversampling_select_o),
      .deep_sleep_o                      (deep_sleep_o)
   );

   assign m.start     = s_q.start;
   assign m.temp_osr  = s_q.temperature_oversampling_select;
   assign m.press_osr = s_q.pressure_oversampling_select;

   logic       busy_now;
   logic [7:0] status_byte;
   logic [7:0] next_byte;
   logic [2:0] next_idx;

   // Start pulse counts as busy so no command slips in before the sequencer reacts;
   // so does the done cycle, as results only turn valid on the edge after it
   assign busy_now = m.busy | s_q.start | m.done;            // [R6] [R7]

   always_comb begin
      status_byte                 = STAT_RESET;              // [R5]
      status_byte[STAT_POWER_BIT] = 1'b1;                    // [R5]
      status_byte[STAT_BUSY_BIT]  = busy_now;                // [R6]
      status_byte[STAT_MODE_BIT]  = test_mode_i;             // [R8]
      status_byte[STAT_CRC_BIT]   = s_q.crc_err;             // [R9]
   end

   // Byte following the current one in the read stream
   assign next_idx = s_q.idx + 3'd1;

   always_comb begin
      next_byte = TX_IDLE_BYTE;
      if (s_q.valid) begin
         unique case (next_idx)                              // [R17]
            3'd1:    next_byte = s_q.press[23:16];
            3'd2:    next_byte = s_q.press[15:8];
            3'd3:    next_byte = s_q.press[7:0];
            3'd4:    next_byte = s_q.temp[15:8];
            3'd5:    next_byte = s_q.temp[7:0];
            default: next_byte = TX_IDLE_BYTE;
         endcase
      end
   end

   always_comb begin
      s_d       = s_q;
      s_d.start = 1'b0;
      // Calibration check result is caught once after reset release
      if (!s_q.crc_taken) begin
         s_d.crc_taken = 1'b1;                               // [R10]
         s_d.crc_err   = cal_crc_fail_i;                     // [R10] [R9]
      end
      // Results are taken while the front end still presents them;
      // the done pulse rises on that same edge; validity follows on the edge after, which ends it
      if (fe_done_i && m.busy) begin
         s_d.press = fe_press_i;                             // [R18]
         s_d.temp  = fe_temp_i;                              // [R19]
      end
      if (m.done) begin
         s_d.valid = 1'b1;                                   // [R6]
      end
      if (ev.stop_det) begin
         s_d.st   = IDLE;
         s_d.oe_n = 1'b1;
      end else if (ev.start_det) begin
         s_d.st       = ADDR;
         s_d.cnt      = 4'd0;
         s_d.oe_n     = 1'b1;
         s_d.cmd_seen = 1'b0;
      end else begin
         unique case (s_q.st)
            IDLE: begin
               s_d.oe_n = 1'b1;
            end
            ADDR: begin
               if (ev.scl_rise) begin
                  s_d.sh  = {s_q.sh[6:0], ev.sda};           // [R20]
                  s_d.cnt = s_q.cnt + 4'd1;
               end else if (ev.scl_fall && s_q.cnt == 4'd8) begin
                  if (s_q.sh[7:1] == SLAVE_ADDR) begin       // [R1]
                     s_d.st   = ADDR_ACK;
                     s_d.oe_n = 1'b0;
                     s_d.rd   = s_q.sh[0];
                  end else begin
                     s_d.st = IDLE;
                  end
               end
            end
            ADDR_ACK: begin
               if (ev.scl_fall) begin
                  s_d.cnt = 4'd0;
                  if (s_q.rd) begin
                     s_d.st   = RD_BYTE;
                     s_d.idx  = 3'd0;
                     s_d.sh   = status_byte;                 // [R2]
                     s_d.oe_n = status_byte[7];              // [R20]
                  end else begin
                     s_d.st   = WR_BYTE;
                     s_d.oe_n = 1'b1;
                  end
               end
            end
            WR_BYTE: begin
               if (ev.scl_rise) begin
                  s_d.sh  = {s_q.sh[6:0], ev.sda};           // [R20]
                  s_d.cnt = s_q.cnt + 4'd1;
               end else if (ev.scl_fall && s_q.cnt == 4'd8) begin
                  s_d.st       = WR_ACK;
                  s_d.oe_n     = 1'b0;
                  s_d.cmd_seen = 1'b1;
                  // Only the first byte after the address is a command
                  if (!s_q.cmd_seen && !busy_now) begin      // [R7] [R15]
                     s_d.valid = 1'b0;                       // [R4]
                     if (s_q.sh == CMD_MEAS_STORED) begin
                        s_d.start = 1'b1;                    // [R11] [R14]
                        s_d.temperature_oversampling_select = cal_temp_osr_i;          // [R11]
                        s_d.pressure_oversampling_select = cal_press_osr_i;         // [R11]
                     end else if (s_q.sh[7:4] == CMD_MEAS_OSR_HI) begin
                        s_d.start = 1'b1;                    // [R12] [R14]
                        s_d.temperature_oversampling_select = s_q.sh[TEMPERATURE_OVERSAMPLING_SELECT_BIT];       // [R13]
                        s_d.pressure_oversampling_select = s_q.sh[PRESSURE_OVERSAMPLING_SELECT_W-1:0];     // [R13]
                     end
                  end
               end
            end
            WR_ACK: begin
               if (ev.scl_fall) begin
                  s_d.st   = WR_BYTE;
                  s_d.oe_n = 1'b1;
                  s_d.cnt  = 4'd0;
               end
            end
            RD_BYTE: begin
               if (ev.scl_fall) begin
                  if (s_q.cnt == 4'd7) begin
                     s_d.st   = RD_ACK;
                     s_d.oe_n = 1'b1;
                  end else begin
                     s_d.sh   = {s_q.sh[6:0], 1'b0};         // [R20]
                     s_d.oe_n = s_q.sh[6];
                     s_d.cnt  = s_q.cnt + 4'd1;
                  end
               end
            end
            RD_ACK: begin
               if (ev.scl_rise && ev.sda) begin
                  s_d.st = IDLE;                             // [R21]
               end else if (ev.scl_fall) begin
                  // Reads leave results untouched, so a reread matches
                  s_d.st   = RD_BYTE;                        // [R3] [R17]
                  s_d.idx  = next_idx;
                  s_d.sh   = next_byte;
                  s_d.oe_n = next_byte[7];
                  s_d.cnt  = 4'd0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_q <= '{st: IDLE, oe_n: 1'b1, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // Open drain: only ever pulls low, release means high
   assign sda_o      = 1'b0;
   assign sda_oe_n_o = s_q.oe_n;
endmodule : pressure_readout
`default_nettype wire

// ---- tb/i2c_host_model.sv ----
// Behavioural bus master standing in for the host controller
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
   // Bus lines
   output logic      scl_o,
   output logic      sda_o,
   input  wire logic sda_i
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // One 160 ns bit; data moves only while the clock is low
   task automatic slot(input logic b, output logic r);
      sda_o = b;
      #40;
      scl_o = 1'b1;
      #40;
      r = sda_i;
      #40;
      scl_o = 1'b0;
      #40;
   endtask : slot
   task automatic frame_start();
      sda_o = 1'b1;
      scl_o = 1'b1;
      #40;
      sda_o = 1'b0;
      #40;
      scl_o = 1'b0;
      #40;
   endtask : frame_start
   // Clock is left high afterwards: it stands still between frames
   task automatic frame_stop();
      sda_o = 1'b0;
      #40;
      scl_o = 1'b1;
      #40;
      sda_o = 1'b1;
      #40;
   endtask : frame_stop
   task automatic wr_byte(input logic [7:0] b, output logic nak);
      logic r;
      for (int i = 7; i >= 0; i--) slot(b[i], r);
      slot(1'b1, nak);
   endtask : wr_byte
   task automatic command(input logic [7:0] adr, input logic [7:0] c, output logic [1:0] nak);
      frame_start();
      wr_byte(adr, nak[1]);
      nak[0] = 1'b1;
      if (nak[1] === 1'b0) wr_byte(c, nak[0]);
      frame_stop();
   endtask : command
   task automatic read6(output logic nak, output logic [47:0] d);
      logic [7:0] b;
      logic       r;
      frame_start();
      wr_byte(8'hF1, nak);
      for (int k = 0; k < 6; k++) begin
         for (int i = 7; i >= 0; i--) slot(1'b1, b[i]);
         slot(k == 5, r);
         d = {d[39:0], b};
      end
      frame_stop();
   endtask : read6
endmodule : i2c_host_model
`default_nettype wire

// ---- tb/pressure_readout_properties.sv ----
// Concurrent checks on the readout block's ports
`timescale 1ns/1ps
`default_nettype none
module pressure_readout_properties #(
   parameter logic [6:0] SLAVE_ADDR = 7'h78
) (
   // Clock and reset
   input wire logic                                  clk_i,
   input wire logic                                  sys_rst_i,
   // Watched ports
   input wire logic                                  scl_i,
   input wire logic                                  sda_o,
   input wire logic                                  sda_oe_n_o,
   input wire logic                                  test_mode_i,
   input wire logic                                  fe_done_i,
   input wire logic                                  fe_start_o,
   input wire logic                                  temperature_oversampling_select_o,
   input wire logic [pressure_readout_pkg::PRESSURE_OVERSAMPLING_SELECT_W-1:0] pressure_oversampling_select_o,
   input wire logic                                  deep_sleep_o
);
   import pressure_readout_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // Conversion in flight, as seen from the front-end handshake
   logic busy_q;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) busy_q <= 1'b0;
      else if (fe_start_o) busy_q <= 1'b1;
      else if (fe_done_i) busy_q <= 1'b0;
   end
   property p_pull_low; sda_o == 1'b0; endproperty
   property p_one_pulse; fe_start_o |=> !fe_start_o; endproperty
   property p_wake; fe_start_o |-> ##[0:2] !deep_sleep_o; endproperty
   property p_sleep; fe_done_i && !test_mode_i |-> ##[1:3] deep_sleep_o; endproperty
   property p_test_awake;
      test_mode_i && $past(test_mode_i, 2) && !$past(sys_rst_i, 3) |-> !deep_sleep_o;
   endproperty
   property p_busy_ignore; fe_start_o |-> !busy_q; endproperty
   property p_osr_hold;
      busy_q && !fe_start_o |-> $stable({temperature_oversampling_select_o,
                                         pressure_oversampling_select_o});
   endproperty
   // Data may only move while the clock is low
   property p_sda_move; $changed(sda_oe_n_o) |-> !scl_i && !$past(scl_i); endproperty
   property p_start_acked; fe_start_o |-> !sda_oe_n_o && !$past(sda_oe_n_o); endproperty
   a_pull_low: assert property (p_pull_low) else $error("sda output not low");
   a_one_pulse: assert property (p_one_pulse) else $error("start pulse too long");
   a_wake: assert property (p_wake) else $error("no wake on start");
   a_sleep: assert property (p_sleep) else $error("no sleep after done");
   a_test_awake: assert property (p_test_awake) else $error("asleep in test mode");
   a_busy_ignore: assert property (p_busy_ignore) else $error("start while busy");
   a_osr_hold: assert property (p_osr_hold) else $error("osr moved while busy");
   a_sda_move: assert property (p_sda_move) else $error("sda moved, scl high");
   a_start_acked: assert property (p_start_acked) else $error("start not in ack");
   c_start: cover property (fe_start_o);
   c_done: cover property (busy_q && fe_done_i);
   c_ack: cover property ($fell(sda_oe_n_o));
   c_test: cover property (test_mode_i && !deep_sleep_o);
endmodule : pressure_readout_properties
bind pressure_readout pressure_readout_properties #(.SLAVE_ADDR(SLAVE_ADDR)) i_props (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i), .sda_o(sda_o),
   .sda_oe_n_o(sda_oe_n_o), .test_mode_i(test_mode_i), .fe_done_i(fe_done_i),
   .fe_start_o(fe_start_o),
   .temperature_oversampling_select_o(temperature_oversampling_select_o),
   .pressure_oversampling_select_o(pressure_oversampling_select_o),
   .deep_sleep_o(deep_sleep_o));
`default_nettype wire

// ---- tb/pressure_readout_tb.sv ----
// Self-checking bench for the pressure readout block
`timescale 1ns/1ps
`default_nettype none
module pressure_readout_tb;
   import pressure_readout_pkg::*;
   logic        clk_i, sys_rst_i, cal_crc_fail_i, cal_temp_osr_i, test_mode_i;
   logic        scl_w, host_sda, sda_o, sda_oe_n_o, fe_start_o, deep_sleep_o, temperature_oversampling_select;
   logic        fe_done_i = 1'b0;
   logic [2:0]  cal_press_osr_i, pressure_oversampling_select;
   logic [23:0] fe_press_i;
   logic [15:0] fe_temp_i;
   logic [1:0]  nk;
   logic [47:0] d;
   wire         sda_w;
   int          n_mismatch = 0, n_checks = 0, n_start = 0, fe_cnt = 0, fe_lat, cyc = 0;
   // Pull-up wins unless one party pulls low
   assign sda_w = host_sda & (sda_oe_n_o | sda_o);
   pressure_readout i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_w),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
      .cal_crc_fail_i(cal_crc_fail_i), .cal_temp_osr_i(cal_temp_osr_i),
      .cal_press_osr_i(cal_press_osr_i), .test_mode_i(test_mode_i),
      .fe_done_i(fe_done_i), .fe_press_i(fe_press_i), .fe_temp_i(fe_temp_i),
      .fe_start_o(fe_start_o), .temperature_oversampling_select_o(temperature_oversampling_select),
      .pressure_oversampling_select_o(pressure_oversampling_select), .deep_sleep_o(deep_sleep_o));
   i2c_host_model i_host (.scl_o(scl_w), .sda_o(host_sda), .sda_i(sda_w));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // Front end answers each start after fe_lat cycles
   always @(negedge clk_i) begin
      fe_done_i <= 1'b0;
      if (fe_cnt != 0) begin
         fe_cnt <= fe_cnt - 1;
         if (fe_cnt == 1) fe_done_i <= 1'b1;
      end else if (fe_start_o === 1'b1) fe_cnt <= fe_lat;
   end
   always @(posedge clk_i) begin
      if (fe_start_o === 1'b1) n_start <= n_start + 1;
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_mismatch++;
         summarize();
      end
   end
   function automatic logic [7:0] stat(input logic b, input logic t, input logic c);
      return {1'b0, 1'b1, b, 1'b0, t, c, 2'b00};
   endfunction : stat
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   task automatic do_reset();
      sys_rst_i = 1'b1;
      repeat (10) @(negedge clk_i);
      sys_rst_i = 1'b0;
   endtask : do_reset
   initial begin
      cal_crc_fail_i = 1'b1;
      cal_temp_osr_i = 1'b1;
      cal_press_osr_i = 3'h5;
      test_mode_i = 1'b0;
      fe_press_i = 24'hE324C4;
      fe_temp_i = 16'h4DE4;
      fe_lat = 3000;
      do_reset();
      repeat (4) @(negedge clk_i);
      cal_crc_fail_i = 1'b0; // Flag must keep the value seen at reset
      i_host.command(8'hE0, CMD_MEAS_STORED, nk);
      chk(nk, 2'b11);
      i_host.read6(nk[0], d);
      chk({nk[0], d}, {1'b0, stat(0, 0, 1), 40'h0});
      i_host.command(8'hF0, CMD_MEAS_STORED, nk);
      chk({nk, temperature_oversampling_select, pressure_oversampling_select}, {2'b00, 1'b1, 3'h5});
      i_host.read6(nk[0], d);
      chk(d[47:40], stat(1, 0, 1));
      i_host.command(8'hF0, 8'hB7, nk);
      chk({nk, temperature_oversampling_select, pressure_oversampling_select}, {2'b00, 1'b1, 3'h5});
      for (int k = 0; k < 4 && d[45] !== 1'b0; k++) i_host.read6(nk[0], d);
      chk(d, {stat(0, 0, 1), 24'hE324C4, 16'h4DE4});
      i_host.read6(nk[0], d);
      chk(d, {stat(0, 0, 1), 24'hE324C4, 16'h4DE4});
      chk({deep_sleep_o, 8'(n_start)}, {1'b1, 8'd1});
      fe_lat = 20;
      for (int c = 0; c < 16; c++) begin
         fe_press_i = PRESS_CODE_LO + 24'(c);
         fe_temp_i = TEMP_CODE_HI - 16'(c);
         i_host.command(8'hF0, {CMD_MEAS_OSR_HI, 4'(c)}, nk);
         chk({nk, temperature_oversampling_select, pressure_oversampling_select}, {2'b00, 4'(c)});
         i_host.read6(nk[0], d);
         chk(d, {stat(0, 0, 1), fe_press_i, fe_temp_i});
      end
      chk(n_start, 17);
      i_host.command(8'hF0, 8'h33, nk);
      i_host.read6(nk[0], d);
      chk({d, 8'(n_start)}, {stat(0, 0, 1), 40'h0, 8'd17});
      test_mode_i = 1'b1;
      repeat (4) @(negedge clk_i);
      chk(deep_sleep_o, 1'b0);
      i_host.read6(nk[0], d);
      chk(d[47:40], stat(0, 1, 1));
      do_reset();
      repeat (4) @(negedge clk_i);
      i_host.read6(nk[0], d);
      chk(d[47:40], stat(0, 1, 0));
      summarize();
   end
endmodule : pressure_readout_tb
`default_nettype wire
